// ===== hdl/burst_port_pkg.sv
// Purpose: Shared constants for the burst SRAM write and address port
// Assumes: Narrow organisation, two byte lanes of nine bits
// Notes:   Wide organisation lanes listed for lane naming only
package burst_port_pkg;
  localparam int ADDR_WIDTH      = 19;
  localparam int LANE_WIDTH      = 9;
  localparam int LANE_COUNT      = 2;
  localparam int WIDE_LANE_COUNT = 4;
  localparam int BURST_BITS      = 2;
  localparam int LANE_FIRST      = 0;
  localparam int LANE_SECOND     = 1;
  localparam logic [1:0] COUNT_RESET = 2'h0;
  localparam logic [1:0] COUNT_STEP  = 2'h1;
  localparam logic [2:0] ST_IDLE  = 3'h1;
  localparam logic [2:0] ST_READ  = 3'h2;
  localparam logic [2:0] ST_WRITE = 3'h4;
endpackage : burst_port_pkg

// ===== hdl/burst_sram_port.sv
// Purpose: Synchronous address, burst and write-decode port of a burst SRAM
// Assumes: All inputs but reset_n synchronous to core_clk; sequence select is static
// Notes:   Array storage lives outside; this block drives its write strobes
`timescale 1ns/1ps
module burst_sram_port
  import burst_port_pkg::*;
(
  input  wire logic                  core_clk,                 // Clock
  input  wire logic                  reset_n,                  // Async reset
  input  wire logic [ADDR_WIDTH-1:0] addr_in,                  // Address pins
  input  wire logic                  chip_enable_n,            // Primary enable
  input  wire logic                  processor_addr_strobe_n,  // Proc strobe
  input  wire logic                  controller_addr_strobe_n, // Ctrl strobe
  input  wire logic                  burst_advance_n,          // Advance
  input  wire logic                  sequence_select,          // 1 interleave
  input  wire logic                  byte_write_gate_n,        // Byte gate
  input  wire logic                  global_write_n,           // Global write
  input  wire logic                  byte_write_first_n,       // Lane 0 enable
  input  wire logic                  byte_write_second_n,      // Lane 1 enable
  input  wire logic [LANE_WIDTH-1:0] data_lane_first_i,        // Lane 0 in
  input  wire logic [LANE_WIDTH-1:0] data_lane_second_i,       // Lane 1 in
  output logic                       data_pins_oe,             // Pins driven
  output logic [ADDR_WIDTH-1:0]      mem_addr,                 // Array address
  output logic [LANE_COUNT-1:0]      mem_lane_write,           // Lane strobes
  output logic [LANE_WIDTH-1:0]      mem_data_first,           // Lane 0 data
  output logic [LANE_WIDTH-1:0]      mem_data_second,          // Lane 1 data
  output logic                       cycle_active,             // Selected
  output logic                       cycle_is_write            // Write cycle
);

  typedef enum logic [2:0] {
    IDLE_S  = ST_IDLE,
    READ_S  = ST_READ,
    WRITE_S = ST_WRITE
  } state_type;

  typedef struct packed {
    state_type                 state;
    logic [ADDR_WIDTH-1:0]     base;
    logic [BURST_BITS-1:0]     count;
    logic                      oe;
    logic [ADDR_WIDTH-1:0]     addr;
    logic [LANE_COUNT-1:0]     wr;
    logic [LANE_WIDTH-1:0]     d0;
    logic [LANE_WIDTH-1:0]     d1;
  } port_type;

  port_type cur_q;
  port_type nxt_d;

  // Low two bits of the burst address for a start and a count
  function automatic logic [1:0] burst_low(input logic [1:0] start,
                                           input logic [1:0] cnt,
                                           input logic       ilv);
    if (ilv) begin
      burst_low = start ^ cnt;
    end else begin
      burst_low = 2'(start + cnt);
    end
  endfunction : burst_low

  logic                  proc_load;
  logic                  ctrl_load;
  logic                  load;
  logic                  byte_qual;
  logic [LANE_COUNT-1:0] lane_wr;
  logic                  any_write;
  logic [1:0]            next_count;

  always_comb begin
    // Processor strobe is ignored unless the part is selected
    proc_load  = !processor_addr_strobe_n && !chip_enable_n;
    // Processor strobe has priority; of the two strobes only the controller strobe can start a write
    ctrl_load  = !controller_addr_strobe_n;
    load       = proc_load || ctrl_load;
    byte_qual  = !byte_write_gate_n;
    lane_wr[LANE_FIRST]  = byte_qual && !byte_write_first_n;
    lane_wr[LANE_SECOND] = byte_qual && !byte_write_second_n;
    if (!global_write_n) begin
      lane_wr = '1;
    end
    any_write  = |lane_wr;
    next_count = cur_q.count;
    if (!burst_advance_n) begin
      next_count = 2'(cur_q.count + COUNT_STEP);
    end
    nxt_d       = cur_q;
    nxt_d.oe    = !(byte_qual &&
                    !(byte_write_first_n && byte_write_second_n));
    nxt_d.wr    = '0;
    nxt_d.d0    = data_lane_first_i;
    nxt_d.d1    = data_lane_second_i;
    case (cur_q.state)
      default: begin
        nxt_d.state = IDLE_S;
      end
      IDLE_S, READ_S, WRITE_S: begin
        if (ctrl_load && chip_enable_n) begin
          nxt_d.state = IDLE_S;
        end else if (proc_load || (ctrl_load && !any_write)) begin
          nxt_d.state = READ_S;
          nxt_d.base  = addr_in;
          nxt_d.count = COUNT_RESET;
        end else if (ctrl_load) begin
          nxt_d.state = WRITE_S;
          nxt_d.base  = addr_in;
          nxt_d.count = COUNT_RESET;
          nxt_d.wr    = lane_wr;
        end else if (cur_q.state != IDLE_S) begin
          nxt_d.count = next_count;
          nxt_d.state = any_write ? WRITE_S : READ_S;
          nxt_d.wr    = lane_wr;
        end
      end
    endcase
    if (load && !(ctrl_load && chip_enable_n)) begin
      nxt_d.addr = addr_in;
    end else begin
      nxt_d.addr = {nxt_d.base[ADDR_WIDTH-1:BURST_BITS],
                    burst_low(nxt_d.base[1:0], nxt_d.count,
                              sequence_select)};
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur_q <= '{state: IDLE_S, oe: 1'b1, default: '0};
    end else begin
      cur_q <= nxt_d;
    end
  end

  assign data_pins_oe    = cur_q.oe;
  assign mem_addr        = cur_q.addr;
  assign mem_lane_write  = cur_q.wr;
  assign mem_data_first  = cur_q.d0;
  assign mem_data_second = cur_q.d1;
  assign cycle_active    = cur_q.state != IDLE_S;
  assign cycle_is_write  = cur_q.state == WRITE_S;

  // Checks
  property p_release;
    @(posedge core_clk) disable iff (!reset_n)
      (!byte_write_gate_n && !byte_write_first_n) |=> !data_pins_oe;
  endproperty
  a_release: assert property (p_release)
    else $error("data pins not released for byte write");

  property p_gate;
    @(posedge core_clk) disable iff (!reset_n)
      (byte_write_gate_n && global_write_n) |=> mem_lane_write == 2'h0;
  endproperty
  a_gate: assert property (p_gate)
    else $error("byte write without gate");

  property p_global;
    @(posedge core_clk) disable iff (!reset_n)
      (processor_addr_strobe_n && !global_write_n &&
       !controller_addr_strobe_n && !chip_enable_n)
      |=> mem_lane_write == 2'h3 && cycle_is_write;
  endproperty
  a_global: assert property (p_global)
    else $error("global write did not write all lanes");

  property p_lane_first;
    @(posedge core_clk) disable iff (!reset_n)
      (global_write_n && !byte_write_gate_n && byte_write_first_n)
      |=> !mem_lane_write[0];
  endproperty
  a_lane_first: assert property (p_lane_first)
    else $error("low lane written without its enable");

  property p_proc_ignored;
    @(posedge core_clk) disable iff (!reset_n)
      (chip_enable_n && controller_addr_strobe_n && !cycle_active)
      |=> !cycle_active;
  endproperty
  a_proc_ignored: assert property (p_proc_ignored)
    else $error("selected while chip enable high");

  property p_proc_load;
    @(posedge core_clk) disable iff (!reset_n)
      (!processor_addr_strobe_n && !chip_enable_n)
      |=> mem_addr == $past(addr_in) && cycle_active && !cycle_is_write;
  endproperty
  a_proc_load: assert property (p_proc_load)
    else $error("processor strobe did not start read");

  property p_wait;
    @(posedge core_clk) disable iff (!reset_n)
      (cycle_active && processor_addr_strobe_n && controller_addr_strobe_n
       && burst_advance_n) |=> $stable(mem_addr);
  endproperty
  a_wait: assert property (p_wait)
    else $error("address moved in wait cycle");

  property p_linear;
    @(posedge core_clk) disable iff (!reset_n)
      (cycle_active && processor_addr_strobe_n && controller_addr_strobe_n
       && !burst_advance_n && !sequence_select)
      |=> mem_addr[1:0] == 2'($past(mem_addr[1:0]) + 2'h1);
  endproperty
  a_linear: assert property (p_linear)
    else $error("linear burst order wrong");

  property p_upper;
    @(posedge core_clk) disable iff (!reset_n)
      (cycle_active && processor_addr_strobe_n && controller_addr_strobe_n)
      |=> mem_addr[ADDR_WIDTH-1:2] == $past(mem_addr[ADDR_WIDTH-1:2]);
  endproperty
  a_upper: assert property (p_upper)
    else $error("upper address changed in burst");

  c_write: cover property (@(posedge core_clk) disable iff (!reset_n)
    !controller_addr_strobe_n && !chip_enable_n && !global_write_n);
  c_burst: cover property (@(posedge core_clk) disable iff (!reset_n)
    cycle_active && !burst_advance_n ##1 !burst_advance_n ##1
    !burst_advance_n);
  c_ilv: cover property (@(posedge core_clk) disable iff (!reset_n)
    cycle_active && sequence_select && !burst_advance_n);
endmodule : burst_sram_port

// ===== sim/sram_ctl_model.sv
// Purpose: Bus controller model driving the burst SRAM port pins
// Assumes: Pins change just after the rising edge
// Notes:   Without a global write or a gated byte enable, both lanes show the inverse of their last value
`timescale 1ns/1ps
module sram_ctl_model
  import burst_port_pkg::*;
(
  input  wire logic             core_clk, // Clock
  output logic [7:0]            ctl,      // ce ps cs adv gate gw b1 b2
  output logic [ADDR_WIDTH-1:0] addr,     // Address pins
  output logic [LANE_WIDTH-1:0] lane_a,   // Lane 0 data
  output logic [LANE_WIDTH-1:0] lane_b    // Lane 1 data
);
  initial begin
    ctl    = 8'hff;
    addr   = 19'h00000;
    lane_a = 9'h000;
    lane_b = 9'h1ff;
  end
  task automatic drive(input logic [7:0] c, input logic [ADDR_WIDTH-1:0] a,
                       input logic [LANE_WIDTH-1:0] x, y);
    @(posedge core_clk);
    // Held for the whole cycle, so stable around the sampling edge
    ctl  <= c;
    addr <= a;
    if (!c[2] || (!c[3] && c[1:0] != 2'h3)) begin
      lane_a <= x;
      lane_b <= y;
    end else begin
      lane_a <= ~lane_a;
      lane_b <= ~lane_b;
    end
  endtask : drive
endmodule : sram_ctl_model

// ===== sim/tb_burst_sram_port.sv
// Purpose: Self-checking bench for the burst SRAM port
// Assumes: Outputs show each edge's inputs one cycle later
// Notes:   Driver notes expectations, a negedge monitor compares them
`timescale 1ns/1ps
module tb_burst_sram_port;
  import burst_port_pkg::*;
  typedef struct packed {
    logic act; logic [ADDR_WIDTH-1:0] adr; logic [1:0] lw;
    logic isw; logic oe; logic [LANE_WIDTH-1:0] da, db;
  } note_type;
  logic core_clk = 1'b0, reset_n = 1'b0, seq_sel = 1'b0, sel_nx = 1'b0;
  logic [7:0] ctl;
  logic [ADDR_WIDTH-1:0] addr, madr, base;
  logic [LANE_WIDTH-1:0] lane_a, lane_b, mda, mdb, la = 9'h000, lb = 9'h1ff;
  logic [1:0] lw, cnt;
  logic oe, act, isw, m_act = 1'b0, m_isw, armed = 1'b0;
  note_type q[$];
  note_type nm;
  int n_mismatch = 0, compares = 0;
  logic [7:0] seq[14] = '{8'h5b, 8'h6b, 8'h7b, 8'h6b, 8'h6b, 8'h6b, 8'h30,
    8'h6b, 8'hbf, 8'hdf, 8'h6b, 8'h5b, 8'h6b, 8'h6b};
  always #12.5 core_clk = ~core_clk;
  sram_ctl_model ctl_m (.core_clk(core_clk), .ctl(ctl), .addr(addr),
    .lane_a(lane_a), .lane_b(lane_b));
  burst_sram_port uut (.core_clk(core_clk), .reset_n(reset_n),
    .addr_in(addr), .chip_enable_n(ctl[7]),
    .processor_addr_strobe_n(ctl[6]), .controller_addr_strobe_n(ctl[5]),
    .burst_advance_n(ctl[4]), .sequence_select(seq_sel),
    .byte_write_gate_n(ctl[3]), .global_write_n(ctl[2]),
    .byte_write_first_n(ctl[1]), .byte_write_second_n(ctl[0]),
    .data_lane_first_i(lane_a), .data_lane_second_i(lane_b),
    .data_pins_oe(oe), .mem_addr(madr), .mem_lane_write(lw),
    .mem_data_first(mda), .mem_data_second(mdb), .cycle_active(act),
    .cycle_is_write(isw));
  task automatic cyc(input logic [7:0] c, input logic [ADDR_WIDTH-1:0] a,
                     input logic [LANE_WIDTH-1:0] x, y);
    logic wr, ldp;
    note_type n;
    ctl_m.drive(c, a, x, y);
    seq_sel <= sel_nx;
    wr  = !c[2] || (!c[3] && c[1:0] != 2'h3);
    ldp = !c[6] && !c[7];
    la  = wr ? x : ~la;
    lb  = wr ? y : ~lb;
    if (ldp || !c[5]) begin
      m_act = ldp || !c[7];
      base  = a;
      cnt   = 2'h0;
      m_isw = wr && !ldp;
    end else if (m_act) begin
      cnt   = cnt + {1'b0, !c[4]};
      m_isw = wr;
    end
    n.act = m_act;
    n.adr = {base[ADDR_WIDTH-1:2],
             sel_nx ? base[1:0] ^ cnt : base[1:0] + cnt};
    n.isw = m_act && m_isw;
    n.lw  = !n.isw ? 2'h0 : !c[2] ? 2'h3 : {!c[0], !c[1]};
    n.oe  = !(!c[3] && c[1:0] != 2'h3);
    n.da  = la;
    n.db  = lb;
    q.push_back(n);
  endtask : cyc
  task automatic check(input string s, input logic [ADDR_WIDTH-1:0] e, g);
    compares++;
    if (e !== g) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask : check
  task automatic stop_test;
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test
  // Notes become due one edge after they are pushed
  always @(negedge core_clk) begin
    if (armed) begin
      nm = q.pop_front();
      if (nm.act) check("mem_addr", nm.adr, madr);
      check("cycle_active", ADDR_WIDTH'(nm.act), ADDR_WIDTH'(act));
      check("cycle_is_write", ADDR_WIDTH'(nm.isw), ADDR_WIDTH'(isw));
      check("mem_lane_write", ADDR_WIDTH'(nm.lw), ADDR_WIDTH'(lw));
      check("data_pins_oe", ADDR_WIDTH'(nm.oe), ADDR_WIDTH'(oe));
      check("mem_data", ADDR_WIDTH'({nm.db, nm.da}),
            ADDR_WIDTH'({mdb, mda}));
    end
    armed = q.size() > 0;
  end
  initial begin
    void'($urandom(32'h4c2668e5));
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 14; i++) begin
      sel_nx = i > 10;
      cyc(seq[i], 19'h12347 - 19'(i / 11 * 5),
          9'(i * 37), 9'(i * 91));
    end
    for (int i = 0; i < 8; i++)
      cyc({4'h5, i[2], 1'b1, i[1:0]}, 19'(i * 4099), 9'h1c3, 9'h03c);
    for (int i = 0; i < 300; i++)
      cyc({$urandom_range(7) == 0, 7'($urandom)}, 19'($urandom),
          9'($urandom), 9'($urandom));
    for (int i = 0; i < 4 && q.size() > 0; i++) @(negedge core_clk);
    if (q.size() > 0) n_mismatch++;
    stop_test();
  end
endmodule : tb_burst_sram_port
